// ===== hw/tmc_pkg.sv
package tmc_pkg;

  // Channel count and register map
  localparam int          CH_COUNT = 4;
  localparam logic [31:0] MODE_CTRL_SECOND_OFS [CH_COUNT] = '{
    32'hfffff608,                     // timer0_mode_ctrl_second
    32'hfffff618,                     // timer1_mode_ctrl_second
    32'h0ffff628,                     // timer2_mode_ctrl_second
    32'hfffff638                      // timer3_mode_ctrl_second
  };
  localparam logic [31:0] STATUS_OFS = 32'hfffff640;

  // Avalon response codes
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_DECERR = 2'h3;

  // Second mode-control register layout, bit 7 down to bit 0
  typedef struct packed {
    logic ovf_halt;                   // overflow_halt
    logic pulse_en;                   // pulse_out_enable
    logic act_lvl;                    // out_active_level
    logic ext_clk;                    // external_clock_select
    logic match_clr;                  // match_clear_enable
    logic rsvd;                       // always reads zero
    logic cc1_mode;                   // cc1_mode_select
    logic cc0_mode;                   // cc0_mode_select
  } tmc_mode_t;

  localparam tmc_mode_t  MODE_RESET      = 8'h20;
  localparam logic [7:0] MODE_WRITE_MASK = 8'hfb;

  // Bus slave states
  typedef enum logic [1:0] {
    BUS_IDLE   = 2'h0,
    BUS_ANSWER = 2'h1
  } tmc_bus_st_t;

  // Avalon-MM request and answer
  typedef struct packed {
    logic [31:0] address;
    logic        read;
    logic        write;
    logic [31:0] writedata;
    logic [3:0]  byteenable;
  } tmc_bus_req_t;

  typedef struct packed {
    logic [31:0] readdata;
    logic        waitrequest;
    logic [1:0]  response;
  } tmc_bus_rsp_t;

  // Per-channel links to counter and first mode register
  typedef struct packed {
    logic count_run;                  // count_run_bit level
    logic run_write;                  // pulse: software wrote 1 to it
    logic overflow;                   // pulse: channel_counter wrapped
    logic cc0_match;                  // pulse: capture_compare_reg0 match
    logic cc1_match;                  // pulse: capture_compare_reg1 match
  } tmc_ch_in_t;

  typedef struct packed {
    logic       count_gate;
    logic       count_hold;
    logic       clear_req;
    logic       ext_clk_sel;
    logic [1:0] cc_compare;
    logic       pulse_pin;
  } tmc_ch_out_t;

endpackage

// ===== hw/tmc_mode_ctrl.sv
// Register access over Avalon-MM was chosen for this implementation.
`timescale 1ns/1ns
module tmc_mode_ctrl #(
  parameter int NCH = tmc_pkg::CH_COUNT
) (
  input  wire logic                  ref_clk,
  input  wire logic                  nrst,
  input  wire tmc_pkg::tmc_bus_req_t bus_req,
  output      tmc_pkg::tmc_bus_rsp_t bus_rsp,
  input  wire tmc_pkg::tmc_ch_in_t   ch_in  [NCH],
  output      tmc_pkg::tmc_ch_out_t  ch_out [NCH]
);
  import tmc_pkg::*;

  typedef struct packed {
    tmc_bus_st_t              bus;
    logic [7:0]               rdata;
    logic [1:0]               resp;
    tmc_mode_t [NCH-1:0]      mode;
    logic [NCH-1:0]           pin;
    logic [NCH-1:0]           halt;
  } tmc_state_t;

  tmc_state_t     s_q;
  tmc_state_t     s_d;
  logic [NCH-1:0] hit;
  logic           stat_hit;
  logic           req;
  logic           wr_commit;
  logic [7:0]     rd_val;

  // Address decode and read mux; only the low byte lane carries data
  always_comb begin
    hit      = '0;
    rd_val   = '0;
    stat_hit = bus_req.address == STATUS_OFS;
    for (int i = 0; i < NCH; i++) begin
      hit[i] = bus_req.address == MODE_CTRL_SECOND_OFS[i];
      if (hit[i]) begin
        rd_val = s_q.mode[i];
      end
    end
    if (stat_hit) begin
      rd_val = 8'({s_q.halt, s_q.pin});
    end
  end

  assign req       = bus_req.read | bus_req.write;
  assign wr_commit = bus_req.write && (s_q.bus == BUS_ANSWER);

  // Next state of bus slave, registers, pins and halt flags
  always_comb begin
    s_d = s_q;
    unique case (s_q.bus)
      BUS_IDLE: begin
        if (req) begin
          s_d.bus   = BUS_ANSWER;
          s_d.rdata = rd_val;
          s_d.resp  = (stat_hit || (|hit)) ? RESP_OKAY : RESP_DECERR;
        end
      end
      BUS_ANSWER: begin
        s_d.bus = BUS_IDLE;
      end
      default: begin                  // Unused codes fall back to idle
        s_d.bus = BUS_IDLE;
      end
    endcase
    for (int i = 0; i < NCH; i++) begin
      // Reserved bit is dropped so it always reads back zero
      if (wr_commit && hit[i] && bus_req.byteenable[0]) begin
        s_d.mode[i] = tmc_mode_t'(bus_req.writedata[7:0]
                                  & MODE_WRITE_MASK);
      end
      // Pin follows level one cycle after the register: a write that flips both
      // enable and level in one go cannot spike the pin
      if (!s_q.mode[i].pulse_en) begin
        s_d.pin[i] = ~s_q.mode[i].act_lvl;
      end else if (s_q.mode[i].cc0_mode && s_q.mode[i].cc1_mode
                   && (ch_in[i].cc0_match || ch_in[i].cc1_match)) begin
        s_d.pin[i] = ~s_q.pin[i];
      end
      // Overflow stop wins over a restart in the same cycle
      if (ch_in[i].overflow && s_q.mode[i].ovf_halt
          && ch_in[i].count_run) begin
        s_d.halt[i] = 1'b1;
      end else if (ch_in[i].run_write) begin
        s_d.halt[i] = 1'b0;
      end
    end
  end

  // All state in one register
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      s_q      <= '0;
      s_q.mode <= {NCH{MODE_RESET}};
    end else begin
      s_q <= s_d;
    end
  end

  // Bus answer: one wait cycle, then data from flops
  assign bus_rsp.readdata    = 32'(s_q.rdata);
  assign bus_rsp.response    = s_q.resp;
  assign bus_rsp.waitrequest = req && (s_q.bus == BUS_IDLE);

  // Channel outputs; event request pins never reach the pulse logic
  for (genvar g = 0; g < NCH; g++) begin : g_ch
    assign ch_out[g].count_gate  = ch_in[g].count_run & ~s_q.halt[g];
    assign ch_out[g].count_hold  = s_q.halt[g];
    assign ch_out[g].clear_req   = s_q.mode[g].match_clr
                                   & s_q.mode[g].cc0_mode
                                   & ch_in[g].cc0_match;
    assign ch_out[g].ext_clk_sel = s_q.mode[g].ext_clk;
    assign ch_out[g].cc_compare  = {s_q.mode[g].cc1_mode,
                                    s_q.mode[g].cc0_mode};
    assign ch_out[g].pulse_pin   = s_q.pin[g];
  end

  // Checks on channel 0 and the bus
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!nrst);

  a_bus_answer_next: assert property (
    req && bus_rsp.waitrequest |=> !bus_rsp.waitrequest
  ) else $error("bus answer late");

  a_write_lands_reg: assert property (
    bus_req.write && !bus_rsp.waitrequest && hit[0]
    && bus_req.byteenable[0]
    |=> s_q.mode[0] == tmc_mode_t'($past(bus_req.writedata[7:0])
                                   & MODE_WRITE_MASK)
  ) else $error("write did not land");

  a_read_returns_reg: assert property (
    bus_req.read && bus_rsp.waitrequest && hit[0]
    |=> bus_rsp.readdata[7:0] == $past(s_q.mode[0])
  ) else $error("read data wrong");

  a_rsvd_reads_zero: assert property (
    !s_q.mode[0].rsvd
  ) else $error("reserved bit set");

  a_pin_idle_level: assert property (
    !s_q.mode[0].pulse_en ##1 !s_q.mode[0].pulse_en
    |-> s_q.pin[0] == ~$past(s_q.mode[0].act_lvl)
  ) else $error("pin not inactive");

  a_no_toggle_capture: assert property (
    s_q.mode[0].pulse_en
    && !(s_q.mode[0].cc0_mode && s_q.mode[0].cc1_mode)
    |=> $stable(s_q.pin[0])
  ) else $error("pin moved in capture");

  a_hold_till_match: assert property (
    s_q.mode[0].pulse_en && !ch_in[0].cc0_match
    && !ch_in[0].cc1_match |=> $stable(s_q.pin[0])
  ) else $error("pin moved without match");

  a_match_toggles: assert property (
    s_q.mode[0].pulse_en && s_q.mode[0].cc0_mode
    && s_q.mode[0].cc1_mode && ch_in[0].cc0_match
    |=> s_q.pin[0] != $past(s_q.pin[0])
  ) else $error("match did not toggle");

  a_halt_on_ovf: assert property (
    ch_in[0].overflow && ch_in[0].count_run && s_q.mode[0].ovf_halt
    |=> s_q.halt[0] && !ch_out[0].count_gate ##0 s_q.halt[0]
  ) else $error("overflow did not halt");

  a_halt_holds: assert property (
    s_q.halt[0] && !ch_in[0].run_write |=> s_q.halt[0]
  ) else $error("halt dropped");

  a_clear_needs_en: assert property (
    ch_in[0].cc0_match && !s_q.mode[0].match_clr
    |-> !ch_out[0].clear_req
  ) else $error("clear without enable");

  a_reset_level: assert property (
    @(posedge ref_clk) disable iff (1'b0)
    !nrst |=> s_q.mode[0] == MODE_RESET && !s_q.pin[0]
  ) else $error("reset value wrong");

  // Bus refusals and answer timing
  a_resp_unmapped: assert property (
    req && bus_rsp.waitrequest && !(|hit) && !stat_hit
    |=> bus_rsp.response == RESP_DECERR
  ) else $error("unmapped address not refused");

  a_resp_mapped: assert property (
    req && bus_rsp.waitrequest && ((|hit) || stat_hit)
    |=> bus_rsp.response == RESP_OKAY
  ) else $error("mapped address refused");

  a_unmapped_reads_zero: assert property (
    bus_req.read && bus_rsp.waitrequest && !(|hit) && !stat_hit
    |=> bus_rsp.readdata == '0
  ) else $error("unmapped read not zero");

  a_answer_then_idle: assert property (
    req && !bus_rsp.waitrequest |=> s_q.bus == BUS_IDLE
  ) else $error("bus answer stuck");

  a_bus_state_legal: assert property (
    s_q.bus == BUS_IDLE || s_q.bus == BUS_ANSWER
  ) else $error("bus state illegal");

  // Register contents move only on an accepted low-lane write
  a_mode_needs_write: assert property (
    !(wr_commit && hit[0]) |=> $stable(s_q.mode[0])
  ) else $error("register changed without write");

  a_lane_off_ignored: assert property (
    bus_req.write && !bus_rsp.waitrequest && !bus_req.byteenable[0]
    |=> $stable(s_q.mode)
  ) else $error("write on idle lane landed");

  a_status_write_ignored: assert property (
    bus_req.write && !bus_rsp.waitrequest && stat_hit
    |=> $stable(s_q.mode)
  ) else $error("status write landed");

  // Pulse pin start level and second match source
  a_enable_starts_idle: assert property (
    !s_q.mode[0].pulse_en ##1 s_q.mode[0].pulse_en
    |-> s_q.pin[0] == ~$past(s_q.mode[0].act_lvl)
  ) else $error("pin not inactive at enable");

  a_cc1_match_toggles: assert property (
    s_q.mode[0].pulse_en && s_q.mode[0].cc0_mode
    && s_q.mode[0].cc1_mode && ch_in[0].cc1_match
    |=> s_q.pin[0] != $past(s_q.pin[0])
  ) else $error("second match did not toggle");

  // Halt flag and count gate
  a_halt_blocks_gate: assert property (
    s_q.halt[0] |-> !ch_out[0].count_gate && ch_out[0].count_hold
  ) else $error("counter runs while halted");

  a_gate_follows_run: assert property (
    !s_q.halt[0] |-> ch_out[0].count_gate == ch_in[0].count_run
  ) else $error("gate does not follow run bit");

  a_halt_needs_ovf: assert property (
    !s_q.halt[0] && !(ch_in[0].overflow && ch_in[0].count_run
                      && s_q.mode[0].ovf_halt) |=> !s_q.halt[0]
  ) else $error("halt without overflow");

  a_rerun_clears: assert property (
    s_q.halt[0] && ch_in[0].run_write && !ch_in[0].overflow
    |=> !s_q.halt[0]
  ) else $error("rerun did not restart");

  // Clear request only on a compare match of register 0
  a_clear_on_match: assert property (
    s_q.mode[0].match_clr && s_q.mode[0].cc0_mode && ch_in[0].cc0_match
    |-> ch_out[0].clear_req
  ) else $error("match clear missed");

  a_clear_needs_cmp: assert property (
    !s_q.mode[0].cc0_mode |-> !ch_out[0].clear_req
  ) else $error("clear in capture mode");

  a_clear_only_reg0: assert property (
    !ch_in[0].cc0_match |-> !ch_out[0].clear_req
  ) else $error("clear without match");

  c_pin_toggle: cover property (
    s_q.mode[0].pulse_en ##1 s_q.pin[0] != $past(s_q.pin[0])
  );
  c_halt_restart: cover property (
    s_q.halt[0] ##[1:20] !s_q.halt[0]
  );
  c_write_commit: cover property (
    wr_commit && hit[0]
  );
  c_unmapped: cover property (
    req && !bus_rsp.waitrequest && bus_rsp.response == RESP_DECERR
  );

  c_match_clear: cover property (
    ch_out[0].clear_req
  );

endmodule

// ===== dv/tmc_tb.sv
`timescale 1ns/1ns
module tb;
  import tmc_pkg::*;
  logic         ref_clk;
  logic         nrst;
  tmc_bus_req_t req;
  tmc_bus_rsp_t rsp;
  tmc_ch_in_t   ch_in  [CH_COUNT];
  tmc_ch_out_t  ch_out [CH_COUNT];
  int           err_count;
  int           comparisons;
  int           cycles;
  logic [31:0]  rdat;
  logic [1:0]   resp;
  logic [7:0]   d;

  tmc_mode_ctrl u_tmc_mode_ctrl (
    .ref_clk(ref_clk),
    .nrst   (nrst),
    .bus_req(req),
    .bus_rsp(rsp),
    .ch_in  (ch_in),
    .ch_out (ch_out)
  );

  // Clock at 100 MHz
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task print_verdict();
    $display("comparisons=%0d err_count=%0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // Bus access; held until waitrequest is seen low, only timeout ends it
  task acc(input logic [31:0] a, input logic w, input logic [7:0] v,
           input logic [3:0] be);
    @(posedge ref_clk);
    req <= '{address: a, read: ~w, write: w, writedata: {24'h0, v},
             byteenable: be};
    do @(posedge ref_clk); while (rsp.waitrequest !== 1'b0);
    rdat = rsp.readdata;
    resp = rsp.response;
    req.read  <= 1'b0;
    req.write <= 1'b0;
  endtask

  // Write then let the pin settle one edge after the register
  task wr(input int c, input logic [7:0] v);
    acc(MODE_CTRL_SECOND_OFS[c], 1'b1, v, 4'h1);
    repeat (2) @(negedge ref_clk);
  endtask

  // One-cycle match pulse, pin looked at after the next edge
  task hit(input logic m0, input logic m1, input logic exp);
    @(posedge ref_clk);
    ch_in[0].cc0_match <= m0;
    ch_in[0].cc1_match <= m1;
    @(posedge ref_clk);
    ch_in[0].cc0_match <= 1'b0;
    ch_in[0].cc1_match <= 1'b0;
    @(negedge ref_clk);
    chk(ch_out[0].pulse_pin, exp);
  endtask

  // Hang guard, well above the length of the sequence
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 3000) begin
      err_count++;
      print_verdict();
    end
  end

  initial begin
    nrst  = 1'b0;
    req   = '0;
    ch_in = '{default: '0};
    repeat (3) @(posedge ref_clk);
    nrst <= 1'b1;
    // Reset values, then an unmapped address
    for (int i = 0; i < CH_COUNT; i++) begin
      acc(MODE_CTRL_SECOND_OFS[i], 1'b0, 8'h00, 4'h1);
      chk(rdat, 32'h20);
    end
    chk(ch_out[0].pulse_pin, 1'b0);
    acc(32'hfffff604, 1'b0, 8'h00, 4'h1);
    chk(rdat, 32'h0);
    chk(resp, RESP_DECERR);
    // Field placement, bit 2 always written zero; idle lane ignored
    for (int i = 0; i < CH_COUNT; i++) begin
      d = (i == 0) ? 8'hfb : 8'h7b;
      wr(i, d);
      acc(MODE_CTRL_SECOND_OFS[i], 1'b0, 8'h00, 4'h1);
      chk(rdat, {24'h0, d & 8'hfb});
      chk({ch_out[i].ext_clk_sel, ch_out[i].cc_compare}, 3'h7);
    end
    acc(MODE_CTRL_SECOND_OFS[0], 1'b1, 8'h00, 4'h0);
    acc(MODE_CTRL_SECOND_OFS[0], 1'b0, 8'h00, 4'h1);
    chk(rdat, 32'hfb);
    // Overflow on all channels; only channel 0 halts until rerun
    @(posedge ref_clk);
    for (int i = 0; i < CH_COUNT; i++) ch_in[i].count_run <= 1'b1;
    for (int i = 0; i < CH_COUNT; i++) ch_in[i].overflow <= 1'b1;
    @(posedge ref_clk);
    for (int i = 0; i < CH_COUNT; i++) ch_in[i].overflow <= 1'b0;
    repeat (3) @(negedge ref_clk);
    for (int i = 0; i < CH_COUNT; i++) begin
      d = (i == 0) ? 8'h02 : 8'h01;
      chk({ch_out[i].count_hold, ch_out[i].count_gate}, d);
    end
    @(posedge ref_clk);
    ch_in[0].run_write <= 1'b1;
    @(posedge ref_clk);
    ch_in[0].run_write <= 1'b0;
    @(negedge ref_clk);
    chk({ch_out[0].count_hold, ch_out[0].count_gate}, 2'h1);
    // Counting stopped before the mode register is touched again
    @(posedge ref_clk);
    for (int i = 0; i < CH_COUNT; i++) ch_in[i].count_run <= 1'b0;
    @(negedge ref_clk);
    // Pulse pin: inactive until first match, then toggles
    chk(ch_out[0].pulse_pin, 1'b0);
    hit(1'b1, 1'b0, 1'b1);
    hit(1'b0, 1'b1, 1'b0);
    hit(1'b1, 1'b1, 1'b1);
    acc(STATUS_OFS, 1'b0, 8'h00, 4'h1);
    chk(rdat, 32'h01);
    wr(0, 8'h23);
    chk(ch_out[0].pulse_pin, 1'b0);
    hit(1'b1, 1'b0, 1'b0);
    wr(0, 8'h03);
    chk(ch_out[0].pulse_pin, 1'b1);
    wr(0, 8'h43);
    chk(ch_out[0].pulse_pin, 1'b1);
    hit(1'b1, 1'b0, 1'b0);
    wr(0, 8'h02);
    hit(1'b1, 1'b1, 1'b1);
    // Match clear needs clear enable and compare mode on register 0
    @(posedge ref_clk);
    ch_in[0].cc0_match <= 1'b1;
    wr(0, 8'h09);
    chk(ch_out[0].clear_req, 1'b1);
    wr(0, 8'h08);
    chk(ch_out[0].clear_req, 1'b0);
    wr(0, 8'h01);
    chk(ch_out[0].clear_req, 1'b0);
    print_verdict();
  end
endmodule
